// ===== rtl/dbwrd_seq.sv
// dram page mode write, cas-before-ras refresh and dma acknowledge sequencer
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
module dbwrd_seq (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wide_periph_bus_sel,
    input wire logic [1:0] dram_width_sel,
    input wire logic req_valid,
    output logic req_ready,
    input wire dbwrd_pkg::dbwrd_req_t req,
    output dbwrd_pkg::dbwrd_dram_t dram,
    output logic dma_ack,
    output logic dma_tc,
    output logic busy
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // page cycles per word, minus one
    function automatic logic [1:0] sub_last(input logic dma, input logic wide,
                                            input logic [1:0] dw);
        logic w16;
        w16 = dma && wide;
        if (dw == dbwrd_pkg::DW_4) begin
            sub_last = w16 ? 2'h3 : 2'h1;
        end else if (dw == dbwrd_pkg::DW_8) begin
            sub_last = w16 ? 2'h1 : 2'h0;
        end else begin
            sub_last = 2'h0;
        end
    endfunction

    function automatic logic [dbwrd_pkg::DQ_W-1:0] next_slice(
        input logic [dbwrd_pkg::DQ_W-1:0] d, input logic [1:0] dw);
        if (dw == dbwrd_pkg::DW_4) begin
            next_slice = d >> 4;
        end else if (dw == dbwrd_pkg::DW_8) begin
            next_slice = d >> 8;
        end else begin
            next_slice = d;
        end
    endfunction

    // ------------------------------------------------------------
    // buffer in the data path
    // ------------------------------------------------------------
    dbwrd_pkg::dbwrd_regs_t r_reg;
    dbwrd_pkg::dbwrd_regs_t r_next;
    logic q_valid;
    logic pop;
    logic bclk;
    dbwrd_pkg::dbwrd_req_t q;

    dbwrd_buf #(.W($bits(dbwrd_pkg::dbwrd_req_t))) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(q_valid),
        .out_ready(pop),
        .out_data(q)
    );

    assign bclk = (r_reg.div == dbwrd_pkg::DIV_W'(dbwrd_pkg::BCLK_DIV - 1));
    // refresh wins over a queued word, but only from idle
    assign pop = bclk && (r_reg.st == dbwrd_pkg::S_IDLE) && !r_reg.ref_pend
                 && q_valid;
    assign dram = r_reg.dram;
    assign dma_ack = r_reg.dack;
    assign dma_tc = r_reg.tc;
    assign busy = (r_reg.st != dbwrd_pkg::S_IDLE);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic expire;
        expire = (r_reg.rtmr == dbwrd_pkg::REF_W'(dbwrd_pkg::REF_CYCLES - 1));
        r_next = r_reg;
        r_next.dack = 1'b0;
        r_next.tc = 1'b0;
        r_next.div = bclk ? '0 : r_reg.div + 1'b1;
        r_next.rtmr = expire ? '0 : r_reg.rtmr + 1'b1;
        if (bclk) begin
            unique case (r_reg.st)
                dbwrd_pkg::S_IDLE: begin
                    if (r_reg.ref_pend) begin
                        r_next.dram.column_strobe_n = 1'b0;
                        r_next.ref_pend = 1'b0;
                        r_next.st = dbwrd_pkg::S_REFC;
                    end else if (q_valid) begin
                        r_next.dram.addr = q.row;
                        r_next.col = q.col;
                        r_next.shift = q.data;
                        r_next.dma = q.dma;
                        r_next.last = q.last;
                        r_next.dw = dram_width_sel;
                        r_next.sub = sub_last(q.dma, wide_periph_bus_sel,
                                              dram_width_sel);
                        r_next.st = dbwrd_pkg::S_ROW;
                    end
                end
                dbwrd_pkg::S_ROW: begin
                    r_next.dram.ras_n = 1'b0;
                    r_next.dram.wr_n = 1'b0;
                    r_next.st = dbwrd_pkg::S_RAS;
                end
                dbwrd_pkg::S_RAS: begin
                    // column comes from the latch: the buffer head may already hold the next word
                    r_next.dram.addr = r_reg.col;
                    r_next.st = dbwrd_pkg::S_COL;
                end
                dbwrd_pkg::S_COL: begin
                    r_next.dram.column_strobe_n = 1'b0;
                    r_next.st = dbwrd_pkg::S_CAS;
                end
                dbwrd_pkg::S_CAS: begin
                    r_next.dram.addr = r_reg.dram.addr + 1'b1;
                    r_next.shift = next_slice(r_reg.shift, r_reg.dw);
                    r_next.st = dbwrd_pkg::S_INC;
                end
                dbwrd_pkg::S_INC: begin
                    r_next.dram.column_strobe_n = 1'b1;
                    r_next.st = dbwrd_pkg::S_PRE;
                end
                dbwrd_pkg::S_PRE: begin
                    if (r_reg.sub != 2'h0) begin
                        r_next.sub = r_reg.sub - 1'b1;
                        r_next.dram.column_strobe_n = 1'b0;
                        r_next.st = dbwrd_pkg::S_CAS;
                    end else begin
                        r_next.dram.ras_n = 1'b1;
                        r_next.dram.wr_n = 1'b1;
                        r_next.dack = r_reg.dma;
                        r_next.tc = r_reg.dma && r_reg.last;
                        r_next.cnt = 1'b1;
                        r_next.st = dbwrd_pkg::S_REC;
                    end
                end
                dbwrd_pkg::S_REC: begin
                    r_next.cnt = 1'b0;
                    if (!r_reg.cnt) begin
                        r_next.st = dbwrd_pkg::S_IDLE;
                    end
                end
                dbwrd_pkg::S_REFC: begin
                    r_next.dram.ras_n = 1'b0;
                    r_next.cnt = 1'b1;
                    r_next.st = dbwrd_pkg::S_REFR;
                end
                dbwrd_pkg::S_REFR: begin
                    r_next.cnt = 1'b0;
                    if (!r_reg.cnt) begin
                        r_next.dram.ras_n = 1'b1;
                        r_next.dram.column_strobe_n = 1'b1;
                        r_next.cnt = 1'b1;
                        r_next.st = dbwrd_pkg::S_REC;
                    end
                end
                default: begin
                    r_next.st = dbwrd_pkg::S_IDLE;
                end
            endcase
        end
        // a timer expiry in the cycle the request is taken is kept
        if (expire) begin
            r_next.ref_pend = 1'b1;
        end
        r_next.dram.dq = r_next.shift;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '{st: dbwrd_pkg::S_IDLE, dram: dbwrd_pkg::DRAM_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int BD = dbwrd_pkg::BCLK_DIV;
    localparam int BD2 = 2 * dbwrd_pkg::BCLK_DIV;
    logic [5:0] ras_hi_cnt;
    logic [2:0] cas_falls;
    logic cas_d;
    logic [2:0] exp_falls;
    logic [dbwrd_pkg::ROW_W-1:0] exp_row;
    logic [dbwrd_pkg::ROW_W-1:0] exp_col;
    logic exp_dma;
    logic exp_last;

    // expectations come from the word leaving the buffer, not from the sequencer state
    // ras counts as long idle after reset, so the first word is not flagged
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ras_hi_cnt <= '1;
            cas_falls <= '0;
            cas_d <= 1'b1;
            exp_falls <= 3'h1;
            exp_row <= '0;
            exp_col <= '0;
            exp_dma <= 1'b0;
            exp_last <= 1'b0;
        end else begin
            cas_d <= dram.column_strobe_n;
            ras_hi_cnt <= !dram.ras_n ? 6'h0 : (&ras_hi_cnt ? ras_hi_cnt : ras_hi_cnt + 1'b1);
            if (dram.ras_n) begin
                cas_falls <= '0;
            end else if (cas_d && !dram.column_strobe_n) begin
                cas_falls <= cas_falls + 1'b1;
            end
            if (pop) begin
                exp_row <= q.row;
                exp_col <= q.col;
                exp_dma <= q.dma;
                exp_last <= q.dma && q.last;
                if (dram_width_sel[1]) begin
                    exp_falls <= 3'h1;
                end else if (q.dma && wide_periph_bus_sel) begin
                    exp_falls <= dram_width_sel[0] ? 3'h2 : 3'h4;
                end else begin
                    exp_falls <= dram_width_sel[0] ? 3'h1 : 3'h2;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // write sequence
    a_row_setup: assert property ($fell(dram.ras_n) && dram.column_strobe_n |->
        $fell(dram.wr_n) && dram.addr == $past(dram.addr, BD))
        else $error("row address not held one bclk before ras and write");
    a_row_value: assert property ($fell(dram.ras_n) && dram.column_strobe_n |->
        dram.addr == exp_row)
        else $error("row address differs from the word taken");
    a_wr_with_ras: assert property (!dram.wr_n |-> !dram.ras_n)
        else $error("write strobe low outside a row access");
    a_col_then_cas: assert property ($fell(dram.ras_n) && dram.column_strobe_n |->
        ##BD (dram.column_strobe_n && !dram.ras_n) ##BD $fell(dram.column_strobe_n))
        else $error("column address or cas out of step after ras");
    a_col_value: assert property ($fell(dram.ras_n) && dram.column_strobe_n |->
        ##BD dram.addr == exp_col)
        else $error("column address differs from the word taken");
    a_col_increment: assert property ($fell(dram.column_strobe_n) && !dram.ras_n |->
        ##BD dram.addr == $past(dram.addr, BD) + 10'h1)
        else $error("column address did not increment one bclk after cas");
    a_cas_precharge: assert property ($fell(dram.column_strobe_n) && !dram.ras_n |->
        ##BD2 $rose(dram.column_strobe_n))
        else $error("cas did not rise one bclk after increment");

    // refresh
    a_ref_order: assert property ($fell(dram.column_strobe_n) && dram.ras_n |->
        ##BD $fell(dram.ras_n))
        else $error("refresh ras did not follow cas by one bclk");
    a_ref_widths: assert property ($fell(dram.ras_n) && !dram.column_strobe_n |->
        ##BD2 ($rose(dram.ras_n) && $rose(dram.column_strobe_n)))
        else $error("refresh pulse widths wrong");
    a_ras_recovery: assert property ($fell(dram.ras_n) |->
        ras_hi_cnt >= 6'(BD2))
        else $error("ras high time too short");
    a_ref_cas_rest: assert property ($rose(dram.ras_n) && $rose(dram.column_strobe_n) |->
        dram.column_strobe_n [*8])
        else $error("cas high time after refresh too short");
    a_ref_idle_only: assert property ($fell(dram.column_strobe_n) && dram.ras_n |->
        $past(r_reg.st) == dbwrd_pkg::S_IDLE)
        else $error("refresh started outside idle");

    // dma acknowledge
    a_tc_with_ack: assert property (dma_tc |-> dma_ack && $rose(dram.ras_n))
        else $error("terminal count without acknowledge");
    a_tc_last_only: assert property (dma_tc |-> exp_last)
        else $error("terminal count on a word not marked last");
    a_ack_subcycles: assert property (dma_ack |-> cas_falls == exp_falls)
        else $error("acknowledge before all page cycles");
    a_ack_at_end: assert property (dma_ack |-> $rose(dram.ras_n) && $rose(dram.wr_n))
        else $error("acknowledge not at the end of the row access");
    a_ack_dma_only: assert property (dma_ack |-> exp_dma)
        else $error("acknowledge for a host word");

    c_refresh: cover property ($fell(dram.column_strobe_n) && dram.ras_n);
    c_ref_first: cover property (bclk && r_reg.ref_pend && q_valid);
    c_page_burst: cover property (dma_ack && cas_falls == 3'h4);
    c_last_dma: cover property (dma_tc);
    c_host_write: cover property ($rose(dram.ras_n) && !r_reg.dma && cas_falls == 3'h2);
endmodule

// ===== rtl/dbwrd_pkg.sv
// shared constants and types of the dram buffer write and refresh sequencer
package dbwrd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int BCLK_NS = 84;
    localparam int BCLK_DIV = (BCLK_NS / CLK_NS < 1) ? 1 : BCLK_NS / CLK_NS;
    localparam int DIV_W = (BCLK_DIV > 1) ? $clog2(BCLK_DIV) : 1;
    localparam int REF_NS = 15600;
    localparam int REF_CYCLES = REF_NS / CLK_NS;
    localparam int REF_W = $clog2(REF_CYCLES + 1);
    localparam int RAS_REC_BCLK = 2;
    localparam int REF_RAS_BCLK = 2;
    localparam int ROW_W = 10;
    localparam int DQ_W = 16;
    // ------------------------------------------------------------
    // width codes
    // ------------------------------------------------------------
    localparam logic [1:0] DW_4 = 2'h0;
    localparam logic [1:0] DW_8 = 2'h1;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ROW = 4'h1,
        S_RAS = 4'h2,
        S_COL = 4'h3,
        S_CAS = 4'h4,
        S_INC = 4'h5,
        S_PRE = 4'h6,
        S_REC = 4'h7,
        S_REFC = 4'h8,
        S_REFR = 4'h9
    } dbwrd_state_t;

    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic [ROW_W-1:0] col;
        logic [DQ_W-1:0] data;
        logic dma;
        logic last;
    } dbwrd_req_t;

    typedef struct packed {
        logic ras_n;
        logic column_strobe_n;
        logic wr_n;
        logic [ROW_W-1:0] addr;
        logic [DQ_W-1:0] dq;
    } dbwrd_dram_t;

    localparam dbwrd_dram_t DRAM_IDLE = '{1'b1, 1'b1, 1'b1, '0, '0};

    typedef struct packed {
        dbwrd_state_t st;
        logic cnt;
        logic [1:0] sub;
        logic [1:0] dw;
        logic [DIV_W-1:0] div;
        logic [REF_W-1:0] rtmr;
        logic ref_pend;
        logic [DQ_W-1:0] shift;
        logic [ROW_W-1:0] col;
        logic dma;
        logic last;
        logic dack;
        logic tc;
        dbwrd_dram_t dram;
    } dbwrd_regs_t;
endpackage

// ===== rtl/dbwrd_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module dbwrd_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } dbwrd_buf_t;

    dbwrd_buf_t b_reg;
    dbwrd_buf_t b_next;
    logic push;
    logic pop;

    // full and empty come straight from the count, so back-pressure is exact
    assign in_ready = (b_reg.cnt != 2'h2);
    assign out_valid = (b_reg.cnt != 2'h0);
    assign out_data = b_reg.mem[b_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        b_next = b_reg;
        if (push) begin
            b_next.mem[b_reg.wp] = in_data;
            b_next.wp = ~b_reg.wp;
        end
        if (pop) begin
            b_next.rp = ~b_reg.rp;
        end
        b_next.cnt = b_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b_reg <= '0;
        end else begin
            b_reg <= b_next;
        end
    end
endmodule

// ===== verif/dbwrd_dram_model.sv
// dram array model that stores every page mode write it sees
`timescale 1ns/1ns
module dbwrd_dram_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire dbwrd_pkg::dbwrd_dram_t dram
);
    // ------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------
    logic [15:0] mem [1024];
    logic cas_q;
    int nwr;
    // a refresh drops cas with ras high, so it must never store a word
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cas_q <= 1'b1;
            nwr <= 0;
        end else begin
            cas_q <= dram.column_strobe_n;
            if (cas_q && !dram.column_strobe_n && !dram.ras_n && !dram.wr_n) begin
                mem[dram.addr] <= dram.dq;
                nwr <= nwr + 1;
            end
        end
    end
endmodule

// ===== verif/dbwrd_seq_tb_top.sv
// self-checking bench for the dram write, refresh and dma sequencer
`timescale 1ns/1ns
module dbwrd_seq_tb_top;
    logic clk;
    logic arst_n;
    logic wide_periph_bus_sel;
    logic [1:0] dram_width_sel;
    logic req_valid;
    logic req_ready;
    dbwrd_pkg::dbwrd_req_t req;
    dbwrd_pkg::dbwrd_dram_t dram;
    logic dma_ack;
    logic dma_tc;
    logic busy;
    int n_errors;
    int checked;
    int n_ack;
    int n_tc;
    logic saw_full;

    dbwrd_seq i_dbwrd_seq (.clk(clk), .arst_n(arst_n), .wide_periph_bus_sel(wide_periph_bus_sel),
        .dram_width_sel(dram_width_sel), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .dram(dram), .dma_ack(dma_ack), .dma_tc(dma_tc), .busy(busy));
    dbwrd_dram_model i_dbwrd_dram_model (.clk(clk), .arst_n(arst_n), .dram(dram));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(negedge clk) begin
        if (dma_ack === 1'b1) n_ack++;
        if (dma_tc === 1'b1) n_tc++;
        if (dma_tc === 1'b1) chk("tc_with_ack", 16'h1, {15'h0, dma_ack});
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // request stays up between words so back-to-back offers are real
    task automatic send(input logic [9:0] r, input logic [9:0] c, input logic [15:0] d,
                        input logic dma, input logic last);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{r, c, d, dma, last};
        for (int i = 0; i < 300 && !req_ready; i++) begin
            saw_full = 1'b1;
            @(negedge clk);
        end
        if (req_ready !== 1'b1) chk("req_ready", 16'h1, {15'h0, req_ready});
        @(posedge clk);
    endtask

    task automatic drop();
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        for (int i = 0; i < 4000 && n < 24; i++) begin
            @(negedge clk);
            n = (busy === 1'b0) ? n + 1 : 0;
        end
        chk("idle", 16'h18, 16'(n));
    endtask

    function automatic logic [15:0] slice(input logic [15:0] d, input int w, input int k);
        return (d >> (k * w)) & ((16'h1 << w) - 16'h1);
    endfunction

    task automatic chk_mem(input logic [15:0] d, input logic [9:0] c, input int w, input int n);
        for (int k = 0; k < n; k++)
            chk("mem", slice(d, w, k), i_dbwrd_dram_model.mem[c + k] & slice(16'hffff, w, 0));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_write_timing();
        logic [9:0] pa;
        dram_width_sel = 2'h0;
        send(10'h2a5, 10'h100, 16'h00c3, 1'b0, 1'b0);
        drop();
        pa = dram.addr;
        for (int i = 0; i < 3000 && !(dram.ras_n === 1'b0 && dram.wr_n === 1'b0); i++) begin
            pa = dram.addr;
            @(negedge clk);
        end
        chk("row_before_ras", 16'h2a5, {6'h0, pa});
        repeat (8) @(negedge clk);
        chk("col_after_ras", 16'h100, {6'h0, dram.addr});
        repeat (8) @(negedge clk);
        chk("cas_after_col", 16'h0, {15'h0, dram.column_strobe_n});
        repeat (8) @(negedge clk);
        chk("col_inc", 16'h101, {6'h0, dram.addr});
        repeat (8) @(negedge clk);
        chk("cas_precharge", 16'h1, {15'h0, dram.column_strobe_n});
        repeat (8) @(negedge clk);
        chk("second_cas", 16'h0, {15'h0, dram.column_strobe_n});
        wait_idle();
        chk_mem(16'h00c3, 10'h100, 4, 2);
    endtask

    // four host words into a slow 4-bit dram: the buffer has to refuse one
    task automatic t_buffer();
        saw_full = 1'b0;
        for (int i = 0; i < 4; i++)
            send(10'h011, 10'(10'h200 + i * 16), 16'(16'h5a + i * 17), 1'b0, 1'b0);
        drop();
        wait_idle();
        chk("buffer_full_seen", 16'h1, {15'h0, saw_full});
        for (int i = 0; i < 4; i++)
            chk_mem(16'(16'h5a + i * 17), 10'(10'h200 + i * 16), 4, 2);
    endtask

    task automatic t_dma_widths();
        int w;
        int ww;
        int n0;
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            wide_periph_bus_sel = c[0];
            dram_width_sel = 2'(c >> 1);
            w = dram_width_sel[1] ? 16 : (dram_width_sel[0] ? 8 : 4);
            ww = c[0] ? 16 : 8;
            w = (w > ww) ? ww : w;
            n_ack = 0;
            n_tc = 0;
            n0 = i_dbwrd_dram_model.nwr;
            send(10'(10'h300 + c), 10'(c * 32), 16'(16'h9a5c + c), 1'b1, 1'b0);
            send(10'(10'h300 + c), 10'(c * 32 + 8), 16'(16'h36e1 + c), 1'b1, 1'b1);
            drop();
            wait_idle();
            chk("ack_count", 16'h2, 16'(n_ack));
            chk("tc_count", 16'h1, 16'(n_tc));
            chk("page_writes", 16'(2 * ww / w), 16'(i_dbwrd_dram_model.nwr - n0));
            chk_mem(16'(16'h9a5c + c), 10'(c * 32), w, ww / w);
            chk_mem(16'(16'h36e1 + c), 10'(c * 32 + 8), w, ww / w);
        end
    endtask

    // a word offered while refresh runs must wait for the whole refresh
    task automatic t_refresh();
        int bad;
        dram_width_sel = 2'h1;
        for (int i = 0; i < 2000 && !(dram.column_strobe_n === 1'b0 && dram.ras_n === 1'b1); i++)
            @(negedge clk);
        req_valid = 1'b1;
        req = '{10'h0f0, 10'h3f0, 16'h00a7, 1'b0, 1'b0};
        @(negedge clk);
        req_valid = 1'b0;
        repeat (7) @(negedge clk);
        chk("ras_after_cas", 16'h0, {15'h0, dram.ras_n});
        repeat (15) @(negedge clk);
        chk("refresh_low", 16'h0, {14'h0, dram.ras_n, dram.column_strobe_n});
        @(negedge clk);
        chk("refresh_end", 16'h3, {14'h0, dram.ras_n, dram.column_strobe_n});
        bad = 0;
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            if (dram.ras_n !== 1'b1 || (i < 8 && dram.column_strobe_n !== 1'b1)) bad++;
        end
        chk("refresh_recovery", 16'h0, 16'(bad));
        wait_idle();
        chk_mem(16'h00a7, 10'h3f0, 8, 1);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        checked = 0;
        n_ack = 0;
        n_tc = 0;
        saw_full = 1'b0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wide_periph_bus_sel = 1'b0;
        dram_width_sel = 2'h0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        chk("reset_state", 16'h7, {13'h0, dram.ras_n, dram.column_strobe_n, dram.wr_n});
        t_write_timing();
        t_buffer();
        t_dma_widths();
        t_refresh();
        test_done();
    end

    // whole run needs well under 20000 clocks
    initial begin
        #600000;
        n_errors++;
        $display("[ERR] watchdog expected done seen hang");
        test_done();
    end
endmodule
